// ==== dram_clk_if.sv ====
// Interface: run control and edge strobes between the sequencer and the link clock generator
interface dram_clk_if;
  logic run;
  logic [7:0] half_div;
  logic rise;
  logic fall;
  logic running;
  logic clock_true;
  logic clock_comp;
  modport gen (input run, input half_div, output rise, output fall, output running,
               output clock_true, output clock_comp);
  modport seq (output run, output half_div, input rise, input fall, input running,
               input clock_true, input clock_comp);
endinterface : dram_clk_if

// ==== dram_clock_gen.sv ====
// Link clock generator: divided differential clock with clean stop and divider reload
module dram_clock_gen import dram_host_pkg::*; (
  // System clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Sequencer side
  dram_clk_if.gen clk_if
);

  logic [7:0] half_cnt_r;
  logic [7:0] div_r;
  logic true_r;
  logic comp_r;
  logic running_r;
  logic half_end;

  assign half_end = (half_cnt_r == div_r);
  // Strobes lead the clock edge they announce, so pins move with the edge
  assign clk_if.fall = running_r & half_end & true_r;
  assign clk_if.rise = running_r & half_end & ~true_r & clk_if.run;
  assign clk_if.running = running_r;
  assign clk_if.clock_true = true_r;
  assign clk_if.clock_comp = comp_r;

  // Half-period counter; the divider is reloaded only while stopped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_r <= 8'h00;
      div_r <= HALF_DIV_RST;
      true_r <= 1'b0;
      comp_r <= 1'b1;
      running_r <= 1'b1;
    end else if (!running_r) begin
      half_cnt_r <= 8'h00;
      div_r <= clk_if.half_div;
      if (clk_if.run) begin
        running_r <= 1'b1;
      end
    end else if (half_end) begin
      half_cnt_r <= 8'h00;
      if (true_r) begin
        true_r <= 1'b0;
        comp_r <= 1'b1;
      end else if (clk_if.run) begin
        true_r <= 1'b1;
        comp_r <= 1'b0;
      end else begin
        running_r <= 1'b0;
      end
    end else begin
      half_cnt_r <= half_cnt_r + 8'h01;
    end
  end

endmodule : dram_clock_gen

// ==== dram_clock_stop_and_command_decode.sv ====
// Host controller: issues two-edge DRAM commands, drives enable and stops or retunes the clock
//
// Decided for this implementation: the Avalon-MM register port and the address map.
module dram_clock_stop_and_command_decode import dram_host_pkg::*; (
  // System clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // DRAM pins
  output logic clock_true,
  output logic clock_comp,
  output logic clock_enable_pin,
  output logic chip_select,
  output logic [5:0] command_address_bus
);

  dram_clk_if clk_if ();

  // Software-facing registers
  logic enable_req_r;
  logic stop_req_r;
  logic [7:0] half_div_r;
  logic [7:0] extra_r;
  logic err_r;
  logic freq_note_r;
  logic pending_r;
  logic [31:0] cmd_r;
  cmd_seq_t seq_r;
  logic [7:0] run_div_r;

  // Bus slave
  logic wait_r;
  logic [31:0] readdata_r;
  logic [31:0] rd_word;
  logic accept;
  logic cmd_legal;
  cmd_seq_t enc;

  // Sequencer
  seq_state_t state_r;
  logic enable_r;
  logic select_r;
  logic [5:0] bus_r;
  logic run_r;
  logic [2:0] idx_r;
  logic sent_r;
  logic tmr_start_r;
  logic [8:0] need_ticks_r;
  logic [8:0] need_sys_r;
  logic tmr_done;
  logic wait_over;

  // Clock generator and wait timer
  dram_clock_gen u_clock_gen (
    .clock(clock),
    .rst_n(rst_n),
    .clk_if(clk_if.gen)
  );

  tick_timer #(.W(TIMER_W)) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(tmr_start_r),
    .tick(clk_if.rise),
    .need_ticks(need_ticks_r),
    .need_sys(need_sys_r),
    .done(tmr_done)
  );

  assign clk_if.run = run_r;
  assign clk_if.half_div = half_div_r;
  // A done left over from the previous wait is ignored while the new one starts
  assign wait_over = tmr_done & ~tmr_start_r;

  // Pins and bus answers come straight from flip-flops
  assign clock_true = clk_if.clock_true;
  assign clock_comp = clk_if.clock_comp;
  assign clock_enable_pin = enable_r;
  assign chip_select = select_r;
  assign command_address_bus = bus_r;
  assign avs_readdata = readdata_r;
  assign avs_waitrequest = wait_r;

  // Encode a command word from software into its sequence of bus words
  function automatic cmd_seq_t encode(input logic [31:0] c);
    cmd_seq_t s;
    logic [2:0] bank;
    logic flag;
    logic burst;
    logic c9;
    logic [6:0] col;
    logic [5:0] maddr;
    logic [7:0] oper;
    s = '0;
    bank = c[CMD_BANK_LSB +: 3];
    flag = c[CMD_FLAG_BIT];
    burst = c[CMD_BURST_BIT];
    c9 = c[CMD_C9_BIT];
    col = c[CMD_COL_LSB +: 7];
    maddr = c[CMD_MADDR_LSB +: 6];
    oper = c[CMD_OPER_LSB +: 8];
    s.len = 3'd2;
    unique case (cmd_kind_t'(c[CMD_KIND_LSB +: 4]))
      KIND_MULTI_PURPOSE: begin
        s.word[0] = {oper[6], OPC_MULTI_PURPOSE};
        s.word[1] = oper[5:0];
      end
      KIND_PRECHARGE: begin
        s.word[0] = {flag, OPC_PRECHARGE};
        s.word[1] = {3'b000, bank};
      end
      KIND_REFRESH: begin
        s.word[0] = {flag, OPC_REFRESH};
        s.word[1] = {3'b000, bank};
      end
      KIND_SELF_REFRESH_ENTRY: begin
        s.word[0] = {1'b0, OPC_SELF_REFRESH_ENTRY};
      end
      KIND_SELF_REFRESH_EXIT: begin
        s.word[0] = {1'b0, OPC_SELF_REFRESH_EXIT};
      end
      KIND_WRITE, KIND_READ: begin
        s.word[0] = {burst, (c[CMD_KIND_LSB +: 4] == KIND_WRITE) ? OPC_WRITE_FIRST : OPC_READ_FIRST};
        s.word[1] = {flag, c9, 1'b0, bank};
        s.word[2] = {col[6], OPC_COLUMN_SECOND};
        s.word[3] = col[5:0];
        s.len = 3'd4;
      end
      KIND_MASK_WRITE: begin
        s.word[0] = {1'b0, OPC_MASK_WRITE_FIRST};
        s.word[1] = {flag, c9, 1'b0, bank};
        s.word[2] = {col[6], OPC_COLUMN_SECOND};
        s.word[3] = col[5:0];
        s.len = 3'd4;
      end
      KIND_MODE_WRITE: begin
        s.word[0] = {oper[7], OPC_MODE_WRITE_FIRST};
        s.word[1] = maddr;
        s.word[2] = {oper[6], OPC_MODE_WRITE_SECOND};
        s.word[3] = oper[5:0];
        s.len = 3'd4;
      end
      KIND_MODE_READ: begin
        s.word[0] = {1'b0, OPC_MODE_READ_FIRST};
        s.word[1] = maddr;
        s.word[2] = {col[6], OPC_COLUMN_SECOND};
        s.word[3] = col[5:0];
        s.len = 3'd4;
      end
      default: begin
        s.len = 3'd0;
      end
    endcase
    return s;
  endfunction : encode

  assign enc = encode(avs_writedata);
  assign accept = (avs_read | avs_write) & ~wait_r;
  // Commands only while enable is wanted high, no stop wanted and no error pending
  assign cmd_legal = (enc.len != 3'd0) & enable_req_r & ~stop_req_r & ~err_r;

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    case (avs_address)
      OFS_CTRL: begin
        rd_word[CTRL_ENABLE_BIT] = enable_req_r;
        rd_word[CTRL_STOP_BIT] = stop_req_r;
        rd_word[CTRL_DIV_LSB +: 8] = half_div_r;
      end
      OFS_CMD: begin
        rd_word = cmd_r;
      end
      OFS_EXTRA: begin
        rd_word[7:0] = extra_r;
      end
      OFS_STATUS: begin
        rd_word[STAT_STATE_LSB +: 3] = state_r;
        rd_word[STAT_ENABLE_BIT] = enable_r;
        rd_word[STAT_RUNNING_BIT] = clk_if.running;
        rd_word[STAT_PENDING_BIT] = pending_r;
        rd_word[STAT_ERR_BIT] = err_r;
        rd_word[STAT_READY_BIT] = (state_r == ST_IDLE);
        rd_word[STAT_FREQ_BIT] = freq_note_r;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Bus handshake: answer one cycle after the request, stall a command write while one is queued
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
      readdata_r <= 32'h0000_0000;
    end else if (!wait_r) begin
      wait_r <= 1'b1;
    end else if ((avs_read | avs_write) && !(avs_write && avs_address == OFS_CMD && pending_r)) begin
      wait_r <= 1'b0;
      readdata_r <= rd_word;
    end
  end

  // Control and timing registers written by software
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_req_r <= 1'b0;
      stop_req_r <= 1'b0;
      half_div_r <= HALF_DIV_RST;
      extra_r <= EXTRA_RST;
    end else if (accept && avs_write) begin
      if (avs_address == OFS_CTRL) begin
        enable_req_r <= avs_writedata[CTRL_ENABLE_BIT];
        stop_req_r <= avs_writedata[CTRL_STOP_BIT];
        half_div_r <= avs_writedata[CTRL_DIV_LSB +: 8];
      end
      if (avs_address == OFS_EXTRA) begin
        extra_r <= avs_writedata[7:0];
      end
    end
  end

  // Command slot: filled by a legal command write, emptied when its last word is sent
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pending_r <= 1'b0;
      cmd_r <= 32'h0000_0000;
      seq_r <= '0;
    end else if (accept && avs_write && avs_address == OFS_CMD && cmd_legal) begin
      pending_r <= 1'b1;
      cmd_r <= avs_writedata;
      seq_r <= enc;
    end else if (sent_r) begin
      pending_r <= 1'b0;
    end
  end

  // Error flag for refused commands; stays until software clears it after re-initialising the part
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      err_r <= 1'b0;
    end else if (accept && avs_write && avs_address == OFS_CMD && !cmd_legal) begin
      err_r <= 1'b1;
    end else if (accept && avs_write && avs_address == OFS_CTRL && avs_writedata[CTRL_CLEAR_ERR_BIT]) begin
      err_r <= 1'b0;
    end
  end

  // Frequency-changed note: set when the clock restarts on a new divider, write one to clear (set wins)
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      freq_note_r <= 1'b0;
      run_div_r <= HALF_DIV_RST;
    end else begin
      if (!clk_if.running && run_r) begin
        run_div_r <= half_div_r;
      end
      if (!clk_if.running && run_r && half_div_r != run_div_r) begin
        freq_note_r <= 1'b1;
      end else if (accept && avs_write && avs_address == OFS_STATUS && avs_writedata[STAT_FREQ_BIT]) begin
        freq_note_r <= 1'b0;
      end
    end
  end

  // Link sequencer: command words, enable pin, clock run and the waits between them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_POWER_DOWN;
      enable_r <= 1'b0;
      select_r <= 1'b0;
      bus_r <= 6'h00;
      run_r <= 1'b1;
      idx_r <= 3'd0;
      sent_r <= 1'b0;
      tmr_start_r <= 1'b0;
      need_ticks_r <= 9'h000;
      need_sys_r <= 9'h000;
    end else begin
      tmr_start_r <= 1'b0;
      sent_r <= 1'b0;
      unique case (state_r)
        ST_POWER_DOWN: begin
          run_r <= ~stop_req_r;
          if (enable_req_r && !stop_req_r && run_r && clk_if.running) begin
            state_r <= ST_CLOCK_VALID;
            tmr_start_r <= 1'b1;
            need_ticks_r <= CLOCK_VALID_NCK;
            need_sys_r <= CLOCK_VALID_SYS;
          end
        end
        ST_CLOCK_VALID: begin
          if (!enable_req_r || stop_req_r) begin
            state_r <= ST_POWER_DOWN;
          end else if (wait_over && clk_if.fall) begin
            enable_r <= 1'b1;
            state_r <= ST_EXIT_WAIT;
            tmr_start_r <= 1'b1;
            need_ticks_r <= EXIT_DELAY_NCK;
            need_sys_r <= EXIT_DELAY_SYS;
          end
        end
        ST_EXIT_WAIT: begin
          if (wait_over) begin
            state_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (clk_if.fall) begin
            if (pending_r) begin
              select_r <= 1'b1;
              bus_r <= seq_r.word[0];
              idx_r <= 3'd1;
              state_r <= ST_COMMAND;
            end else if (!enable_req_r || stop_req_r) begin
              state_r <= ST_DRAIN;
              tmr_start_r <= 1'b1;
              need_ticks_r <= DRAIN_BASE_NCK + {1'b0, extra_r};
              need_sys_r <= CMD_TO_ENABLE_LOW_SYS;
            end
          end
        end
        ST_COMMAND: begin
          if (clk_if.fall) begin
            if (idx_r == seq_r.len) begin
              select_r <= 1'b0;
              bus_r <= 6'h00;
              sent_r <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              select_r <= ~idx_r[0];
              bus_r <= seq_r.word[idx_r[1:0]];
              idx_r <= idx_r + 3'd1;
            end
          end
        end
        ST_DRAIN: begin
          if (enable_req_r && !stop_req_r) begin
            state_r <= ST_IDLE;
          end else if (wait_over && clk_if.fall) begin
            if (!enable_req_r) begin
              enable_r <= 1'b0;
              state_r <= ST_HOLD_LOW;
              tmr_start_r <= 1'b1;
              need_ticks_r <= CLOCK_HOLD_NCK;
              need_sys_r <= CLOCK_HOLD_SYS;
            end else begin
              run_r <= 1'b0;
              state_r <= ST_STOPPED;
            end
          end
        end
        ST_HOLD_LOW: begin
          if (wait_over) begin
            state_r <= ST_POWER_DOWN;
          end
        end
        ST_STOPPED: begin
          if (!stop_req_r && !clk_if.running) begin
            run_r <= 1'b1;
            state_r <= ST_EXIT_WAIT;
            tmr_start_r <= 1'b1;
            need_ticks_r <= RESTART_EXTRA_NCK + EXIT_DELAY_NCK;
            need_sys_r <= EXIT_DELAY_SYS;
          end
        end
      endcase
    end
  end

endmodule : dram_clock_stop_and_command_decode

// ==== dram_clock_stop_and_command_decode_tb.sv ====
// Testbench: register-driven commands, clock stop and restart of the DRAM host
module dram_clock_stop_and_command_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdat;
  logic avs_waitrequest, clock_true, clock_comp, clock_enable_pin, chip_select;
  logic [5:0] command_address_bus, w1, w2;
  logic [4:0] opc [10] = '{5'h00, 5'h10, 5'h08, 5'h18, 5'h14, 5'h04, 5'h0c, 5'h02, 5'h06, 5'h0e};
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int base;
  dram_clock_stop_and_command_decode DUT (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .clock_true, .clock_comp, .clock_enable_pin, .chip_select, .command_address_bus);
  dram_dev_model dev (.clock_true, .clock_comp, .clock_enable_pin, .chip_select, .command_address_bus);
  initial forever #5 clock = ~clock;
  // Cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      $display("mismatch at %0t: timeout", $time);
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One transfer, held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [4:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask : wr
  task automatic rd(input logic [4:0] a); xfer(1'b0, a, 32'h0); endtask : rd
  task automatic wait_state(input logic [2:0] s);
    rd(5'h0c);
    for (int i = 0; i < 300 && rdat[2:0] !== s; i++) rd(5'h0c);
  endtask : wait_state
  // Bank 5, flag, burst, C9 and column 7'h55 set in every command
  task automatic issue(input logic [3:0] k, input int n);
    base = dev.second_q.size();
    wr(5'h04, 32'h157d0 | k);
    for (int i = 0; i < 400 && dev.second_q.size() < base + n; i++) @(posedge clock);
  endtask : issue
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(5'h0c);
    chk(rdat & 32'h1ff, 32'h10);
    rd(5'h10);
    chk(rdat, 32'h0);
    wr(5'h04, 32'h2);
    rd(5'h0c);
    chk(rdat & 32'h7f, 32'h50);
    $display("test reset and refusal done");
    wr(5'h00, 32'h105);
    wait_state(3'h3);
    chk(rdat & 32'h1ff, 32'h9b);
    for (int k = 0; k < 10; k++) begin
      issue(k[3:0], (k inside {5, 6, 7, 8, 9}) ? 2 : 1);
      w1 = dev.first_q[base];
      w2 = dev.second_q[base];
      chk(w1[4:0], opc[k]);
      if (k inside {5, 6, 7, 9}) chk({dev.first_q[base + 1], dev.second_q[base + 1]}, 12'hc95);
      if (k inside {1, 2}) chk({w1[5], w2[2:0]}, 4'hd);
      if (k inside {5, 7}) chk({w1[5], w2[5:4], w2[2:0]}, 6'h3d);
      if (k == 8) chk(dev.first_q[base + 1][4:0], 5'h16);
    end
    $display("test command words done");
    wr(5'h00, 32'h203);
    wait_state(3'h7);
    repeat (20) @(posedge clock);
    chk({clock_true, clock_comp, chip_select, clock_enable_pin}, 4'h5);
    base = dev.first_q.size();
    wr(5'h04, 32'h157d2);
    rd(5'h0c);
    chk({rdat[6], 28'(dev.first_q.size() - base)}, 29'h10000000);
    $display("test clock stop done");
    wr(5'h00, 32'h205);
    wait_state(3'h3);
    chk(rdat[8], 1'b1);
    issue(4'h7, 2);
    chk(dev.first_q[base][4:0], 5'h02);
    $display("test restart done");
    wr(5'h00, 32'h200);
    wait_state(3'h0);
    chk(clock_enable_pin, 1'b0);
    wr(5'h00, 32'h202);
    rd(5'h0c);
    for (int i = 0; i < 300 && rdat[4] !== 1'b0; i++) rd(5'h0c);
    chk(rdat[4:0], 5'h00);
    $display("test enable low stop done");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(5'h0c);
    chk(rdat & 32'h1ff, 32'h10);
    $display("test second reset done");
    close_out();
  end
endmodule : dram_clock_stop_and_command_decode_tb

// ==== dram_dev_model.sv ====
// Device model: takes two-edge commands off the link at clock rises
module dram_dev_model (
  // Link pins
  input wire logic clock_true,
  input wire logic clock_comp,
  input wire logic clock_enable_pin,
  input wire logic chip_select,
  input wire logic [5:0] command_address_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] first_q[$];
  logic [5:0] second_q[$];
  logic second_r = 1'b0;
  // First word on a selected rise, second word on the rise after it
  always @(posedge clock_true) begin
    if (second_r) begin
      second_q.push_back(command_address_bus);
      second_r <= 1'b0;
    end else if (chip_select && clock_enable_pin) begin
      first_q.push_back(command_address_bus);
      second_r <= 1'b1;
    end
  end
endmodule : dram_dev_model

// ==== dram_host_checker.sv ====
// Checker: pin timing and bus answers of the DRAM host
module dram_host_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // DRAM pins
  input wire logic clock_true,
  input wire logic clock_comp,
  input wire logic clock_enable_pin,
  input wire logic chip_select,
  input wire logic [5:0] command_address_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Column-second word begins a few link clocks later
  sequence col_next;
    ##[2:40] ($rose(chip_select) && command_address_bus[4:0] == 5'h12);
  endsequence
  chk_clock_pair: assert property (clock_true != clock_comp)
    else $error("clock pair not complementary");
  chk_select_enable: assert property (chip_select |-> clock_enable_pin)
    else $error("select without enable");
  chk_select_edge: assert property ($changed(chip_select) |-> $fell(clock_true))
    else $error("select moved off a fall");
  chk_bus_edge: assert property ($changed(command_address_bus) |-> $fell(clock_true))
    else $error("bus moved off a fall");
  chk_enable_edge: assert property ($changed(clock_enable_pin) |-> $fell(clock_true))
    else $error("enable moved off a fall");
  chk_column_follow: assert property ($rose(chip_select) && command_address_bus[4:0] inside
    {5'h04, 5'h0c, 5'h02, 5'h0e} |-> col_next)
    else $error("column word missing");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  chk_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read not answered");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && (avs_address[4] || avs_address[1:0] != 0)
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : dram_host_checker
bind dram_clock_stop_and_command_decode dram_host_checker chk_i (.clock, .rst_n, .avs_address, .avs_read,
  .avs_readdata, .avs_waitrequest, .clock_true, .clock_comp, .clock_enable_pin, .chip_select, .command_address_bus);

// ==== dram_host_pkg.sv ====
// Package: register map, command encodings and link timing for the DRAM clock and command host
package dram_host_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_CMD = 5'h04;
  localparam logic [4:0] OFS_EXTRA = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0c;

  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_CLEAR_ERR_BIT = 2;
  localparam int CTRL_DIV_LSB = 8;

  // Command register fields
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_BANK_LSB = 4;
  localparam int CMD_FLAG_BIT = 7;
  localparam int CMD_BURST_BIT = 8;
  localparam int CMD_C9_BIT = 9;
  localparam int CMD_COL_LSB = 10;
  localparam int CMD_MADDR_LSB = 17;
  localparam int CMD_OPER_LSB = 23;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_ENABLE_BIT = 3;
  localparam int STAT_RUNNING_BIT = 4;
  localparam int STAT_PENDING_BIT = 5;
  localparam int STAT_ERR_BIT = 6;
  localparam int STAT_READY_BIT = 7;
  localparam int STAT_FREQ_BIT = 8;

  // Values after reset
  localparam logic [7:0] HALF_DIV_RST = 8'h01;
  localparam logic [7:0] EXTRA_RST = 8'h00;

  // Link timing: printed times in ps, clock-count parts in link clocks
  localparam int TIMER_W = 9;
  localparam int unsigned SYS_PERIOD_PS = 10000;
  localparam int unsigned CMD_TO_ENABLE_LOW_PS = 1750;
  localparam int unsigned CLOCK_HOLD_AFTER_ENABLE_LOW_PS = 5000;
  localparam int unsigned CLOCK_VALID_BEFORE_ENABLE_HIGH_PS = 1750;
  localparam int unsigned POWERDOWN_EXIT_DELAY_PS = 7500;
  localparam logic [8:0] CMD_TO_ENABLE_LOW_SYS = 9'((CMD_TO_ENABLE_LOW_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
  localparam logic [8:0] CLOCK_HOLD_SYS = 9'((CLOCK_HOLD_AFTER_ENABLE_LOW_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
  localparam logic [8:0] CLOCK_VALID_SYS = 9'((CLOCK_VALID_BEFORE_ENABLE_HIGH_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
  localparam logic [8:0] EXIT_DELAY_SYS = 9'((POWERDOWN_EXIT_DELAY_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
  localparam logic [8:0] CMD_TO_ENABLE_LOW_NCK = 9'h003;
  localparam logic [8:0] CLOCK_HOLD_NCK = 9'h005;
  localparam logic [8:0] CLOCK_VALID_NCK = 9'h003;
  localparam logic [8:0] EXIT_DELAY_NCK = 9'h005;
  localparam logic [8:0] RESTART_EXTRA_NCK = 9'h002;
  localparam logic [8:0] STOP_EXTRA_NCK = 9'h004;
  localparam logic [8:0] DRAIN_BASE_NCK = (STOP_EXTRA_NCK > CMD_TO_ENABLE_LOW_NCK) ? STOP_EXTRA_NCK
                                                                                  : CMD_TO_ENABLE_LOW_NCK;

  // First-edge opcodes on bus bits 4..0 (bit i is bus bit i)
  localparam logic [4:0] OPC_MULTI_PURPOSE = 5'h00;
  localparam logic [4:0] OPC_PRECHARGE = 5'h10;
  localparam logic [4:0] OPC_REFRESH = 5'h08;
  localparam logic [4:0] OPC_SELF_REFRESH_ENTRY = 5'h18;
  localparam logic [4:0] OPC_WRITE_FIRST = 5'h04;
  localparam logic [4:0] OPC_SELF_REFRESH_EXIT = 5'h14;
  localparam logic [4:0] OPC_MASK_WRITE_FIRST = 5'h0c;
  localparam logic [4:0] OPC_READ_FIRST = 5'h02;
  localparam logic [4:0] OPC_COLUMN_SECOND = 5'h12;
  localparam logic [4:0] OPC_MODE_WRITE_FIRST = 5'h06;
  localparam logic [4:0] OPC_MODE_WRITE_SECOND = 5'h16;
  localparam logic [4:0] OPC_MODE_READ_FIRST = 5'h0e;

  // Command kinds accepted from software
  typedef enum logic [3:0] {
    KIND_MULTI_PURPOSE = 4'b0000,
    KIND_PRECHARGE = 4'b0001,
    KIND_REFRESH = 4'b0010,
    KIND_SELF_REFRESH_ENTRY = 4'b0011,
    KIND_SELF_REFRESH_EXIT = 4'b0100,
    KIND_WRITE = 4'b0101,
    KIND_MASK_WRITE = 4'b0110,
    KIND_READ = 4'b0111,
    KIND_MODE_WRITE = 4'b1000,
    KIND_MODE_READ = 4'b1001
  } cmd_kind_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_POWER_DOWN = 3'b000,
    ST_CLOCK_VALID = 3'b001,
    ST_EXIT_WAIT = 3'b010,
    ST_IDLE = 3'b011,
    ST_COMMAND = 3'b100,
    ST_DRAIN = 3'b101,
    ST_HOLD_LOW = 3'b110,
    ST_STOPPED = 3'b111
  } seq_state_t;

  // Encoded bus words of one command, sent in order from word 0
  typedef struct packed {
    logic [2:0] len;
    logic [3:0][5:0] word;
  } cmd_seq_t;

endpackage : dram_host_pkg

// ==== tick_timer.sv ====
// Wait timer: counts link clock rises and system cycles until both minimums are met
module tick_timer #(
  parameter int W = 9
) (
  // System clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Wait control
  input wire logic start,
  input wire logic tick,
  input wire logic [W-1:0] need_ticks,
  input wire logic [W-1:0] need_sys,
  output logic done
);

  logic [W:0] tick_cnt_r;
  logic [W:0] sys_cnt_r;
  logic done_r;

  assign done = done_r;

  // Saturating counters, cleared by start
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
      sys_cnt_r <= '0;
      done_r <= 1'b0;
    end else if (start) begin
      tick_cnt_r <= '0;
      sys_cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      if (tick && !tick_cnt_r[W]) begin
        tick_cnt_r <= tick_cnt_r + (W+1)'(1);
      end
      if (!sys_cnt_r[W]) begin
        sys_cnt_r <= sys_cnt_r + (W+1)'(1);
      end
      done_r <= (tick_cnt_r >= {1'b0, need_ticks}) && (sys_cnt_r >= {1'b0, need_sys});
    end
  end

endmodule : tick_timer
